/* src/tce_timer.sv */
// Purpose: 16-bit timer with two capture/compare registers and square output
// Assumes: one clock, synchronous active-high reset, synchronous pins
// Notes: registers sit on a plain strobe port with read data one cycle later
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tce_cfg.svh"
module tce_timer
  import tce_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic [`TCE_ADDR_W-1:0] I_ADDR,
  input wire logic [`TCE_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [`TCE_DATA_W-1:0] O_RDATA,
  input wire logic I_TRIG_A,
  input wire logic I_TRIG_B,
  output logic O_TIMER_OUT,
  output logic O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  generate
    if (CNT_W < 2 || CNT_W > `TCE_DATA_W) begin : g_bad_width
      $error("counter width must fit the data bus");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [CNT_W-1:0] count; // main_count_register
  logic [CNT_W-1:0] next_count; // counter next value
  logic [CNT_W-1:0] cc_a; // compare_capture_a
  logic [CNT_W-1:0] cc_b; // compare_capture_b
  logic [`TCE_MODE_W-1:0] mode_reg; // timer_mode_register
  logic single_in; // capture_control_register bit
  tce_edge_t es_a; // edge_select_a field
  tce_edge_t es_b; // edge_select_b field
  logic oe_bit; // output_enable_bit
  logic tog_bit; // toggle_on_match_bit
  logic [`TCE_SCS_W-1:0] sample_rate_select; // sample_rate_select
  tce_irq_t irq_stat; // sticky status
  tce_irq_t irq_mask; // enable mask
  tce_irq_t irq_set; // this cycle's events
  logic [`TCE_DIV_W-1:0] div_cnt; // sample divider
  logic [`TCE_DIV_W-1:0] div_last; // divider terminal value
  logic smp_tick; // sample enable for input a
  tce_edge_ev_t ev_a; // filtered edges of input a
  tce_edge_ev_t ev_b; // filtered edges of input b
  tce_mode_t mode; // decoded mode
  logic running; // any counting mode
  logic meas; // capture modes
  logic hit_a; // valid edge on input a
  logic hit_b; // valid edge on input b
  logic opp_a; // opposite edge on input a
  logic match; // counter equals compare a
  logic match_evt; // match in a clearing mode
  logic cap_b_en; // load compare_capture_b
  logic cap_a_en; // load compare_capture_a
  logic [`TCE_DATA_W-1:0] rd_mux; // read data source

  // write strobe for one offset
  function automatic logic wr_at(input logic [`TCE_ADDR_W-1:0] ofs);
    wr_at = I_WR && (I_ADDR == ofs);
  endfunction : wr_at

  ////////////////////////////////////////////////////////////////////////////
  // sample clock divider: period of 2 to the power sample_rate_select cycles
  assign div_last = `TCE_DIV_W'((1 << sample_rate_select) - 1);
  assign smp_tick = (div_cnt == div_last);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      div_cnt <= '0;
    end else if (smp_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input filters; input b is sampled every cycle, still two samples deep
  tce_filter u_filt_a (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_tick(smp_tick),
    .i_pin(I_TRIG_A),
    .o_ev(ev_a)
  );

  tce_filter u_filt_b (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_tick(1'b1),
    .i_pin(I_TRIG_B),
    .o_ev(ev_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event decode
  always_comb begin
    mode = tce_mode_t'(mode_reg);
    unique case (mode)
      MODE_FREE, MODE_RESTART: begin
        running = 1'b1;
        meas = 1'b1;
      end
      MODE_EVENT, MODE_SQUARE: begin
        running = 1'b1;
        meas = 1'b0;
      end
      // stop and the unused codes hold the counter at zero
      default: begin
        running = 1'b0;
        meas = 1'b0;
      end
    endcase
  end

  assign hit_a = tce_edge_hit(es_a, ev_a);
  assign hit_b = tce_edge_hit(es_b, ev_b);
  // opposite-edge decode yields nothing when both edges are selected
  assign opp_a = tce_edge_opp(es_a, ev_a);
  assign match = (count == cc_a);
  assign match_evt = match && (mode == MODE_EVENT || mode == MODE_SQUARE);

  // in free-running mode without single input both inputs own a capture path, so two widths run at once
  assign cap_b_en = meas && hit_a;
  assign cap_a_en = meas && (single_in ? opp_a : (mode == MODE_FREE && hit_b));

  ////////////////////////////////////////////////////////////////////////////
  // counter next value
  always_comb begin
    next_count = count;
    unique case (mode)
      MODE_FREE: begin
        next_count = count + 1'b1;
      end
      MODE_RESTART: begin
        // capture and clear land together at the next edge, count resumes after
        next_count = hit_a ? '0 : count + 1'b1;
      end
      MODE_EVENT: begin
        if (match) begin
          // an edge in the clearing cycle is kept as the first count
          next_count = {{(CNT_W-1){1'b0}}, hit_a};
        end else if (hit_a) begin
          next_count = count + 1'b1;
        end
      end
      MODE_SQUARE: begin
        next_count = match ? '0 : count + 1'b1;
      end
      default: begin
        next_count = '0;
      end
    endcase
  end

  // counter register; software only reads it
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture/compare registers; a capture beats a software write
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      cc_a <= '0;
    end else if (cap_a_en) begin
      cc_a <= count;
    end else if (wr_at(`TCE_OFS_CCA)) begin
      cc_a <= I_WDATA[CNT_W-1:0];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      cc_b <= '0;
    end else if (cap_b_en) begin
      cc_b <= count;
    end else if (wr_at(`TCE_OFS_CCB)) begin
      cc_b <= I_WDATA[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      mode_reg <= `TCE_MODE_RST;
      single_in <= 1'b0;
      es_a <= tce_edge_t'(`TCE_EDGE_RST);
      es_b <= tce_edge_t'(`TCE_EDGE_RST);
      oe_bit <= 1'b0;
      tog_bit <= 1'b0;
      sample_rate_select <= `TCE_SCS_RST;
    end else if (I_WR) begin
      unique case (I_ADDR)
        `TCE_OFS_MODE: mode_reg <= I_WDATA[`TCE_MODE_W-1:0];
        `TCE_OFS_CAPCTL: single_in <= I_WDATA[`TCE_SINGLE_BIT];
        `TCE_OFS_EDGE: begin
          es_a <= tce_edge_t'(I_WDATA[`TCE_ES_A_LO +: 2]);
          es_b <= tce_edge_t'(I_WDATA[`TCE_ES_B_LO +: 2]);
        end
        `TCE_OFS_OUTCTL: begin
          oe_bit <= I_WDATA[`TCE_OE_BIT];
          tog_bit <= I_WDATA[`TCE_TOG_BIT];
        end
        `TCE_OFS_SCS: sample_rate_select <= I_WDATA[`TCE_SCS_W-1:0];
        // other offsets carry no control state
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // square output; the pin rests low while the output is disabled
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || !oe_bit) begin
      O_TIMER_OUT <= 1'b0;
    end else if (mode == MODE_SQUARE && match && tog_bit) begin
      O_TIMER_OUT <= !O_TIMER_OUT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write one to clear, set wins over clear
  assign irq_set.cap_a = running && hit_a;
  assign irq_set.cap_b = running && hit_b;
  assign irq_set.match = match_evt;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      irq_stat <= `TCE_IRQ_RST;
    end else if (wr_at(`TCE_OFS_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~tce_irq_t'(I_WDATA[2:0])) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      irq_mask <= `TCE_IRQ_RST;
    end else if (wr_at(`TCE_OFS_IRQ_MASK)) begin
      irq_mask <= tce_irq_t'(I_WDATA[2:0]);
    end
  end

  // level output built from flops only
  assign O_IRQ = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped offsets read zero
  always_comb begin
    unique case (I_ADDR)
      `TCE_OFS_COUNT: rd_mux = `TCE_DATA_W'(count);
      `TCE_OFS_CCA: rd_mux = `TCE_DATA_W'(cc_a);
      `TCE_OFS_CCB: rd_mux = `TCE_DATA_W'(cc_b);
      `TCE_OFS_MODE: rd_mux = `TCE_DATA_W'(mode_reg);
      `TCE_OFS_CAPCTL: rd_mux = `TCE_DATA_W'(single_in);
      `TCE_OFS_EDGE: rd_mux = `TCE_DATA_W'({es_b, es_a, 2'h0});
      `TCE_OFS_OUTCTL: rd_mux = `TCE_DATA_W'({tog_bit, oe_bit});
      `TCE_OFS_SCS: rd_mux = `TCE_DATA_W'(sample_rate_select);
      `TCE_OFS_IRQ_STAT: rd_mux = `TCE_DATA_W'(irq_stat);
      `TCE_OFS_IRQ_MASK: rd_mux = `TCE_DATA_W'(irq_mask);
      default: rd_mux = '0;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || !I_RD) begin
      O_RDATA <= '0;
    end else begin
      O_RDATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  chk_cap_b_load: assert property (meas && hit_a |=> cc_b == $past(count))
    else $error("capture b missed input a edge");
  chk_irq_a_set: assert property (running && hit_a |=> irq_stat.cap_a)
    else $error("capture a flag not set");
  chk_cap_a_trig_b: assert property (mode == MODE_FREE && !single_in && hit_b
    |=> cc_a == $past(count) && irq_stat.cap_b)
    else $error("capture a missed input b edge");
  chk_single_opp: assert property (meas && single_in && es_a == EDGE_RISE && ev_a.fall
    |=> cc_a == $past(count))
    else $error("opposite edge did not load capture a");
  chk_both_no_cap: assert property (single_in && es_a == EDGE_BOTH
    && !wr_at(`TCE_OFS_CCA) |=> $stable(cc_a))
    else $error("capture a loaded with both edges selected");
  chk_restart_seq: assert property (mode == MODE_RESTART && hit_a
    && !wr_at(`TCE_OFS_MODE) |=> count == '0 ##1 count == 1)
    else $error("restart did not clear and resume");
  chk_event_inc: assert property (mode == MODE_EVENT && !match
    |=> count == $past(count) + $past(hit_a))
    else $error("event count wrong");
  chk_event_match: assert property (mode == MODE_EVENT && match
    |=> count == CNT_W'($past(hit_a)) && irq_stat.match)
    else $error("event match did not clear");
  chk_square_flip: assert property (mode == MODE_SQUARE && match && oe_bit && tog_bit
    && !wr_at(`TCE_OFS_OUTCTL) |=> O_TIMER_OUT != $past(O_TIMER_OUT))
    else $error("square output did not invert");
  chk_free_wrap: assert property (mode == MODE_FREE && (&count) |=> count == '0)
    else $error("free counter did not wrap");

  cov_restart: cover property (mode == MODE_RESTART && hit_a);
  cov_event_match: cover property (mode == MODE_EVENT && match && count != '0);
  cov_square_flip: cover property (mode == MODE_SQUARE && match && oe_bit && tog_bit);
  cov_two_caps: cover property (mode == MODE_FREE && cap_a_en && cap_b_en);

endmodule : tce_timer
`default_nettype wire

/* src/tce_cfg.svh */
// Purpose: offsets, field positions, reset values and counts of the timer block
// Assumes: plain register port, 16-bit data, word index addresses
// Notes: definitions only, no logic
//
// Summary of operation
// - free-running mode without single input captures both inputs independently
// - free-running and restart modes: input a edge copies count into capture b
// - free-running mode without single input: input b edge copies count into capture a
// - edge field picks rising, falling or both
// - input a edge needs two equal samples
// - single-input mode, free-running or restart: opposite a edge loads capture a
// - single-input mode, both edges selected: no edge loads capture a
// - restart mode: capture, clear counter, keep counting
// - event mode counts each selected, filtered input a edge
// - event mode: match with capture a clears, interrupts
// - square mode: enable and toggle bits invert pin
`ifndef TCE_CFG_SVH
`define TCE_CFG_SVH

// bus geometry
`define TCE_ADDR_W 4
`define TCE_DATA_W 16

// register word offsets
`define TCE_OFS_COUNT 4'h0
`define TCE_OFS_CCA 4'h1
`define TCE_OFS_CCB 4'h2
`define TCE_OFS_MODE 4'h3
`define TCE_OFS_CAPCTL 4'h4
`define TCE_OFS_EDGE 4'h5
`define TCE_OFS_OUTCTL 4'h6
`define TCE_OFS_SCS 4'h7
`define TCE_OFS_IRQ_STAT 4'h8
`define TCE_OFS_IRQ_MASK 4'h9

// field positions
`define TCE_ES_A_LO 2
`define TCE_ES_B_LO 4
`define TCE_OE_BIT 0
`define TCE_TOG_BIT 1
`define TCE_SINGLE_BIT 0

// field widths
`define TCE_MODE_W 3
`define TCE_SCS_W 2
`define TCE_DIV_W 3

// reset values
`define TCE_MODE_RST 3'h0
`define TCE_EDGE_RST 2'h0
`define TCE_SCS_RST 2'h0
`define TCE_IRQ_RST 3'h0

`endif

/* src/tce_pkg.sv */
// Purpose: types shared by the timer block
// Assumes: nothing beyond the cfg header
// Notes: the hit decoder is used by both inputs, the opposite-edge decoder by input a only
`default_nettype none
package tce_pkg;

  // counter operating modes
  typedef enum logic [2:0] {
    MODE_STOP = 3'b000,
    MODE_FREE = 3'b001,
    MODE_RESTART = 3'b010,
    MODE_EVENT = 3'b011,
    MODE_SQUARE = 3'b100
  } tce_mode_t;

  // valid edge selection codes
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } tce_edge_t;

  // filtered edge pulses of one input
  typedef struct packed {
    logic rise;
    logic fall;
  } tce_edge_ev_t;

  // interrupt status and mask layout
  typedef struct packed {
    logic match;
    logic cap_b;
    logic cap_a;
  } tce_irq_t;

  // edge selected by the field was seen
  function automatic logic tce_edge_hit(input tce_edge_t sel, input tce_edge_ev_t ev);
    case (sel)
      EDGE_FALL: tce_edge_hit = ev.fall;
      EDGE_RISE: tce_edge_hit = ev.rise;
      EDGE_BOTH: tce_edge_hit = ev.rise | ev.fall;
      default: tce_edge_hit = 1'b0;
    endcase
  endfunction : tce_edge_hit

  // edge opposite to the selected one; none when both are selected
  function automatic logic tce_edge_opp(input tce_edge_t sel, input tce_edge_ev_t ev);
    case (sel)
      EDGE_FALL: tce_edge_opp = ev.rise;
      EDGE_RISE: tce_edge_opp = ev.fall;
      default: tce_edge_opp = 1'b0;
    endcase
  endfunction : tce_edge_opp

endpackage : tce_pkg
`default_nettype wire

/* src/tce_filter.sv */
// Purpose: sampled noise filter and edge detector for one trigger input
// Assumes: pin is synchronous to the clock
// Notes: a new level is accepted only when two successive samples agree
`timescale 1ns/1ps
`default_nettype none
module tce_filter
  import tce_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_tick,
  input wire logic i_pin,
  output tce_edge_ev_t o_ev
);

  logic smp; // previous sample
  logic lvl; // accepted level

  ////////////////////////////////////////////////////////////////////////////
  // sample register and accepted level
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      smp <= 1'b0;
      lvl <= 1'b0;
    end else if (i_tick) begin
      smp <= i_pin;
      // two equal samples move the level; a one-sample glitch does not
      if (i_pin == smp) begin
        lvl <= i_pin;
      end
    end
  end

  // edge pulses, one cycle each, registered
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ev <= '0;
    end else begin
      o_ev.rise <= i_tick && i_pin && smp && !lvl;
      o_ev.fall <= i_tick && !i_pin && !smp && lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_filter_rise: assert property (@(posedge i_clk) disable iff (i_srst)
    o_ev.rise |-> $past(i_tick) && $past(i_pin) && $past(smp) && !$past(lvl))
    else $error("rise without two high samples");
  chk_filter_fall: assert property (@(posedge i_clk) disable iff (i_srst)
    o_ev.fall |-> $past(i_tick) && !$past(i_pin) && !$past(smp) && $past(lvl))
    else $error("fall without two low samples");

endmodule : tce_filter
`default_nettype wire

/* testbench/tce_pulse_src.sv */
// Purpose: pulse sources on both trigger inputs and the load on the timer pin
// Assumes: trigger levels change just after a rising clock edge
// Notes: the bench calls hold() to shape pulses; gap holds the last toggle spacing
`timescale 1ns/1ps
`default_nettype none
module tce_pulse_src (
  input wire logic i_clk,
  input wire logic i_pin,
  output var logic o_trig_a,
  output var logic o_trig_b
);
  logic last_pin = 1'b0; // pin level seen one edge earlier
  logic [15:0] run = 16'h0; // cycles since the last toggle
  logic [15:0] gap = 16'h0; // spacing of the two latest toggles

  initial begin
    o_trig_a = 1'b0;
    o_trig_b = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // drive both sources to a level and keep it n cycles; a short hold is
  // how the bench makes a noise pulse, nothing else misbehaves here
  task automatic hold(input logic a, input logic b, input int n);
    @(posedge i_clk);
    o_trig_a <= a;
    o_trig_b <= b;
    repeat (n - 1) @(posedge i_clk);
  endtask : hold

  ////////////////////////////////////////////////////////////////////////
  // load side: time each change of the output pin
  always @(posedge i_clk) begin
    last_pin <= i_pin;
    if (i_pin !== last_pin) begin
      gap <= run;
      run <= 16'h1;
    end else begin
      run <= run + 16'h1;
    end
  end
endmodule : tce_pulse_src
`default_nettype wire

/* testbench/tce_timer_tb.sv */
// Purpose: self-checking bench of the timer with capture and square output
// Assumes: an 8-bit counter instance so that wrap-around is quick to reach
// Notes: edge rows first, then reset, noise, wrap, restart, event and square cases
`timescale 1ns/1ps
`default_nettype none
`include "tce_cfg.svh"
module tce_timer_tb;
  logic core_clk; // 200 MHz core clock
  logic srst; // synchronous reset
  logic [3:0] addr; // register index
  logic [15:0] wdata; // write data
  logic wr; // write strobe
  logic rd; // read strobe
  logic [15:0] rdata; // read data
  logic trig_a; // trigger input a from the source model
  logic trig_b; // trigger input b from the source model
  logic timer_out; // square-wave pin
  logic irq; // interrupt level
  int errors = 0; // mismatches
  int checked = 0; // comparisons
  logic [15:0] v; // scratch read value
  logic [15:0] c1; // first capture or count
  // rows: [7:6] edge code, [5:3] status after rise, [2:0] status after fall
  logic [7:0] rows [4] = '{8'h03, 8'h58, 8'h80, 8'hdb};
  logic [3:0] zofs [5] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hf}; // reset-zero places

  tce_timer #(.CNT_W(8)) uut (
    .I_CORE_CLK(core_clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TRIG_A(trig_a), .I_TRIG_B(trig_b),
    .O_TIMER_OUT(timer_out), .O_IRQ(irq)
  );
  tce_pulse_src src (.i_clk(core_clk), .i_pin(timer_out), .o_trig_a(trig_a), .o_trig_b(trig_b));

  ////////////////////////////////////////////////////////////////////////
  // bus tasks: one-cycle strobes, read data taken in the following cycle
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t value mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the tests need about 750 cycles
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    wreg(`TCE_OFS_MODE, 16'h0001);
    // edge rows: both inputs share a code, status shows each capture path
    for (int i = 0; i < 4; i++) begin
      wreg(`TCE_OFS_EDGE, {10'h0, rows[i][7:6], rows[i][7:6], 2'h0});
      wreg(`TCE_OFS_IRQ_STAT, 16'h0007);
      src.hold(1'b1, 1'b1, 8);
      rreg(`TCE_OFS_IRQ_STAT, v);
      chk(v, {13'h0, rows[i][5:3]});
      wreg(`TCE_OFS_IRQ_STAT, 16'h0007);
      src.hold(1'b0, 1'b0, 8);
      rreg(`TCE_OFS_IRQ_STAT, v);
      chk(v, {13'h0, rows[i][2:0]});
    end
    // second reset in mid-run: load mask and rate first so the reset has work to do
    wreg(`TCE_OFS_IRQ_MASK, 16'h0007);
    wreg(`TCE_OFS_SCS, 16'h0003);
    #1 chk({15'h0, irq}, 16'h1);
    // registers back to zero, outputs low
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    #1 chk({14'h0, irq, timer_out}, 16'h0);
    wreg(`TCE_OFS_COUNT, 16'h00aa); // the count is read-only
    rreg(`TCE_OFS_COUNT, v);
    chk(v, 16'h0);
    foreach (zofs[i]) begin
      rreg(zofs[i], v);
      chk(v, 16'h0);
    end
    // noise: a 3-cycle pulse is seen at most once at a 4-cycle sample period
    wreg(`TCE_OFS_MODE, 16'h0001);
    wreg(`TCE_OFS_EDGE, 16'h000c);
    wreg(`TCE_OFS_SCS, 16'h0002);
    src.hold(1'b1, 1'b0, 3);
    src.hold(1'b0, 1'b0, 12);
    rreg(`TCE_OFS_IRQ_STAT, v);
    chk(v, 16'h0);
    src.hold(1'b1, 1'b0, 12);
    rreg(`TCE_OFS_IRQ_STAT, v);
    chk(v, 16'h0001);
    wreg(`TCE_OFS_SCS, 16'h0000);
    // free run: 300 cycles between samples wraps the 8-bit count
    rreg(`TCE_OFS_COUNT, c1);
    repeat (298) @(posedge core_clk);
    rreg(`TCE_OFS_COUNT, v);
    chk(v, {8'h0, c1[7:0] + 8'd44});
    // single input, rising edge: fall loads capture a, width is the difference
    wreg(`TCE_OFS_CAPCTL, 16'h0001);
    wreg(`TCE_OFS_EDGE, 16'h0004);
    src.hold(1'b0, 1'b0, 2);
    src.hold(1'b1, 1'b0, 17);
    src.hold(1'b0, 1'b0, 10);
    rreg(`TCE_OFS_CCB, c1);
    rreg(`TCE_OFS_CCA, v);
    chk((v - c1) & 16'h00ff, 16'd17);
    // both edges chosen: capture a keeps what software wrote
    wreg(`TCE_OFS_EDGE, 16'h000c);
    wreg(`TCE_OFS_CCA, 16'h0055);
    src.hold(1'b1, 1'b0, 10);
    src.hold(1'b0, 1'b0, 10);
    rreg(`TCE_OFS_CCA, v);
    chk(v, 16'h0055);
    // restart: rises 40 cycles apart capture 39 after the clear
    wreg(`TCE_OFS_CAPCTL, 16'h0000);
    wreg(`TCE_OFS_MODE, 16'h0002);
    wreg(`TCE_OFS_EDGE, 16'h0004);
    src.hold(1'b1, 1'b0, 10);
    src.hold(1'b0, 1'b0, 30);
    src.hold(1'b1, 1'b0, 10);
    src.hold(1'b0, 1'b0, 10);
    rreg(`TCE_OFS_CCB, v);
    chk(v, 16'd39);
    // event counting up to a match at five
    wreg(`TCE_OFS_MODE, 16'h0000);
    wreg(`TCE_OFS_CCA, 16'h0005);
    wreg(`TCE_OFS_IRQ_STAT, 16'h0007);
    wreg(`TCE_OFS_MODE, 16'h0003);
    repeat (3) begin
      src.hold(1'b1, 1'b0, 4);
      src.hold(1'b0, 1'b0, 4);
    end
    rreg(`TCE_OFS_COUNT, v);
    chk(v, 16'd3);
    repeat (2) begin
      src.hold(1'b1, 1'b0, 4);
      src.hold(1'b0, 1'b0, 4);
    end
    rreg(`TCE_OFS_COUNT, v);
    chk(v, 16'd0);
    rreg(`TCE_OFS_IRQ_STAT, v);
    chk(v & 16'h0004, 16'h0004);
    chk({15'h0, irq}, 16'h0); // masked out
    wreg(`TCE_OFS_IRQ_MASK, 16'h0004);
    #1 chk({15'h0, irq}, 16'h1);
    wreg(`TCE_OFS_IRQ_STAT, 16'h0007);
    #1 chk({15'h0, irq}, 16'h0);
    // square wave: the pin turns every CCA+1 cycles, low when disabled
    wreg(`TCE_OFS_MODE, 16'h0000);
    wreg(`TCE_OFS_CCA, 16'h0009);
    wreg(`TCE_OFS_OUTCTL, 16'h0003);
    wreg(`TCE_OFS_MODE, 16'h0004);
    repeat (60) @(posedge core_clk);
    #1 chk(src.gap, 16'd10);
    wreg(`TCE_OFS_OUTCTL, 16'h0000);
    repeat (2) @(posedge core_clk);
    #1 chk({15'h0, timer_out}, 16'h0);
    conclude();
  end
endmodule : tce_timer_tb
`default_nettype wire
